// *** hw/int_wake_ctrl.sv ***
// What this block does
// - serial flag set on byte, address match, timeout
// - serial vector needs both enables and stack room
// - serial flag cleared by service
// - any vector call clears global enable
// - uart request on any of six conditions
// - uart vector needs both enables and room
// - uart service clears combined uart flag only
// - individual uart status flags left untouched
// - eeprom flag set at erase/write end
// - eeprom vector needs enables and stack room
// - eeprom service clears eeprom flag
// - filter flag set on ready rising edge
// - filter vector needs enables and stack room
// - filter service clears filter flag
// - flag rise wakes from sleep/idle, enables ignored
// - software presets flag to block wake-up
// - flags stay set until serviced or cleared
// - service clears group flag, software clears sources
// - only program counter is pushed
// - return_from_interrupt restores pc, sets global enable
// - plain return restores pc, keeps enable clear
// - software avoids calls inside service routines
//
// file: the interrupt request and wake-up controller end
// assumes: peripheral events are one-cycle pulses on clk_sys_i;
// filter_ready_status and uart conditions are levels from outside
`timescale 1ns/1ps
`include "int_wake_defs.svh"

module int_wake_ctrl
  import int_wake_pkg::*;
(
  input wire logic clk_sys_i,                // system clock
  input wire logic resetn_i,                 // async reset, active low
  int_wake_if.ctrl core,                     // to core sequencer
  input wire logic ser_byte_done_i,          // serial byte rx/tx done
  input wire logic ser_addr_match_i,         // two-wire address match
  input wire logic ser_timeout_i,            // two-wire bus timeout
  input wire logic [`NUM_UART_COND-1:0] uart_status_flags_i, // uart conditions
  input wire logic ee_erase_done_i,          // eeprom erase cycle end
  input wire logic ee_write_done_i,          // eeprom write cycle end
  input wire logic filter_ready_status_i,    // filter amp ready level
  input wire logic low_power_i,              // in sleep or idle mode
  input wire logic [`NUM_SRC-1:0] int_en_i,  // per-source enables
  input wire logic gie_set_i,                // software sets global enable
  input wire logic gie_clr_i,                // software clears global enable
  input wire logic [`NUM_SRC-1:0] flag_set_i, // software sets flags
  input wire logic [`NUM_SRC-1:0] flag_clr_i, // software clears flags
  output logic [`NUM_SRC-1:0] req_flags_o,   // request flags
  output logic wake_o                        // wake-up pulse
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [`NUM_UART_COND-1:0] uart_s1_q;
  logic [`NUM_UART_COND-1:0] uart_s2_q;
  logic filt_s1_q;
  logic filt_s2_q;
  logic filt_prev_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uart_s1_q <= '0;
      uart_s2_q <= '0;
      filt_s1_q <= 1'b0;
      filt_s2_q <= 1'b0;
      filt_prev_q <= 1'b0;
    end else begin
      uart_s1_q <= uart_status_flags_i;
      uart_s2_q <= uart_s1_q;
      filt_s1_q <= filter_ready_status_i;
      filt_s2_q <= filt_s1_q;
      filt_prev_q <= filt_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // request flags
  // ---------------------------------------------------------------
  logic uart_prev_q;
  src_vec_t hw_set;
  src_vec_t svc_clr;
  src_vec_t flags;
  src_vec_t rises;
  logic uart_any;

  // uart conditions are read only, never cleared here
  assign uart_any = |uart_s2_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uart_prev_q <= 1'b0;
    end else begin
      uart_prev_q <= uart_any;
    end
  end

  always_comb begin
    hw_set = '0;
    hw_set[`SRC_SERIAL] = ser_byte_done_i | ser_addr_match_i | ser_timeout_i;
    hw_set[`SRC_UART] = uart_any & ~uart_prev_q;
    hw_set[`SRC_EEPROM] = ee_erase_done_i | ee_write_done_i;
    hw_set[`SRC_FILTER] = filt_s2_q & ~filt_prev_q;
  end

  // service clears only the flag of the vector taken
  always_comb begin
    svc_clr = '0;
    if (core.vec_take) begin
      svc_clr[core.vec_id] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g++) begin : gen_flag
      req_flag u_flag (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .set_i     (hw_set[g]),
        .sw_set_i  (flag_set_i[g]),
        .clr_i     (svc_clr[g] | flag_clr_i[g]),
        .flag_o    (flags[g]),
        .rise_o    (rises[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // global enable
  // ---------------------------------------------------------------
  logic gie_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gie_q <= 1'b0;
    end else if (core.vec_take) begin
      gie_q <= 1'b0;
    end else if (core.return_from_interrupt || gie_set_i) begin
      gie_q <= 1'b1;
    end else if (gie_clr_i) begin
      gie_q <= 1'b0; // plain return leaves it as is
    end
  end

  // ---------------------------------------------------------------
  // request arbitration
  // ---------------------------------------------------------------
  src_vec_t pend;
  logic vec_req_d;
  vec_t vec_id_d;
  logic vec_req_q;
  vec_t vec_id_q;

  assign pend = flags & int_en_i & ~svc_clr;

  // fixed priority, lowest index first
  always_comb begin
    vec_req_d = 1'b0;
    vec_id_d = '0;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        vec_req_d = 1'b1;
        vec_id_d = vec_t'(i);
      end
    end
    if (!gie_q || core.vec_take || core.stack_full) begin
      vec_req_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vec_req_q <= 1'b0;
      vec_id_q <= '0;
    end else begin
      vec_req_q <= vec_req_d;
      vec_id_q <= vec_id_d;
    end
  end

  // ---------------------------------------------------------------
  // wake-up and outputs
  // ---------------------------------------------------------------
  logic wake_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= low_power_i & (|rises);
    end
  end

  logic [`NUM_SRC-1:0] flags_q;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags;
    end
  end

  assign core.vec_req = vec_req_q;
  assign core.vec_id = vec_id_q;
  assign core.gie = gie_q;
  assign req_flags_o = flags_q;
  assign wake_o = wake_q;
endmodule

// *** hw/int_wake_defs.svh ***
// header: constants for the peripheral interrupt and wake-up logic
// assumes: included by bare name from the package and design files
`ifndef INT_WAKE_DEFS_SVH
`define INT_WAKE_DEFS_SVH

// source indices, also the fixed priority order (lowest index wins)
`define SRC_SERIAL 0
`define SRC_UART 1
`define SRC_EEPROM 2
`define SRC_FILTER 3
`define NUM_SRC 4
`define NUM_UART_COND 6
`define PC_W 12
`define VEC_W 2
`define STACK_DEPTH 8
`define STACK_PTR_W 4
`define PC_RESET 12'h000

`endif

// *** hw/int_wake_pkg.sv ***
// package: shared types for the interrupt controller and its core end
// assumes: int_wake_defs.svh is on the include path
`include "int_wake_defs.svh"

package int_wake_pkg;
  typedef logic [`NUM_SRC-1:0] src_vec_t;
  typedef logic [`PC_W-1:0] pc_t;
  typedef logic [`VEC_W-1:0] vec_t;
  typedef enum logic [1:0] {
    CORE_RUN = 2'b00,
    CORE_CALL = 2'b01,
    CORE_ISR = 2'b11
  } core_state_e;
endpackage

// *** hw/int_wake_if.sv ***
// interface: joins the interrupt controller to the core sequencer
// assumes: both ends run on one clock and one reset
`timescale 1ns/1ps
`include "int_wake_defs.svh"

interface int_wake_if;
  import int_wake_pkg::*;
  logic vec_req;      // controller asks for a vector call
  logic [`VEC_W-1:0] vec_id; // which vector
  logic vec_take;     // core takes the call this cycle
  logic stack_full;   // core has no stack room
  logic return_from_interrupt;         // return_from_interrupt executed
  logic ret;          // plain return executed
  logic gie;          // global_int_en as held by controller

  modport ctrl (output vec_req, output vec_id, output gie,
                input vec_take, input stack_full, input return_from_interrupt, input ret);
  modport core (input vec_req, input vec_id, input gie,
                output vec_take, output stack_full, output return_from_interrupt, output ret);
endinterface

// *** hw/req_flag.sv ***
// module: one sticky request flag with rising-edge wake-up pulse
// assumes: all inputs are on clk_sys_i
`timescale 1ns/1ps

module req_flag (
  input wire logic clk_sys_i, // system clock
  input wire logic resetn_i,  // async reset, active low
  input wire logic set_i,     // hardware event
  input wire logic sw_set_i,  // software set
  input wire logic clr_i,     // software or service clear
  output logic flag_o,        // request flag
  output logic rise_o         // flag goes low to high at the next edge
);
  logic flag_q;
  logic flag_d;

  // set wins over clear; flag holds until cleared
  always_comb begin
    flag_d = flag_q;
    if (clr_i) begin
      flag_d = 1'b0;
    end
    if (set_i || sw_set_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;
  assign rise_o = flag_d & ~flag_q;
endmodule

// *** hw/int_wake_core.sv ***
// file: core sequencer end, takes vectors and keeps the pc stack
// assumes: controller on the same clock; return strobes are pulses
`timescale 1ns/1ps
`include "int_wake_defs.svh"

module int_wake_core
  import int_wake_pkg::*;
(
  input wire logic clk_sys_i,        // system clock
  input wire logic resetn_i,         // async reset, active low
  int_wake_if.core ctrl,             // to interrupt controller
  input wire logic [`PC_W-1:0] pc_i, // current program counter
  input wire logic return_from_interrupt_i,           // execute return_from_interrupt
  input wire logic ret_i,            // execute plain return
  output logic [`PC_W-1:0] pc_o,     // restored or vector pc
  output logic pc_load_o,            // load pc_o this cycle
  output logic in_isr_o              // servicing an interrupt
);
  logic [`PC_W-1:0] stack_q [`STACK_DEPTH];
  logic [`STACK_PTR_W-1:0] sp_q;
  logic take;
  logic pop;
  logic stack_full;
  logic [`PC_W-1:0] pc_q;
  logic load_q;
  core_state_e state_q;
  logic isr_q;

  assign stack_full = (sp_q == `STACK_PTR_W'(`STACK_DEPTH));
  // request lags the global enable by a cycle, so gate on it here too
  assign take = ctrl.vec_req & ctrl.gie & ~stack_full & (state_q == CORE_RUN);
  assign pop = (return_from_interrupt_i | ret_i) & (sp_q != '0);

  // only the pc is pushed
  always_ff @(posedge clk_sys_i) begin
    if (take) begin
      stack_q[sp_q[`STACK_PTR_W-2:0]] <= pc_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp_q <= '0;
    end else if (take) begin
      sp_q <= sp_q + 1'b1;
    end else if (pop) begin
      sp_q <= sp_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= CORE_RUN;
    end else begin
      case (state_q)
        CORE_RUN: if (take) state_q <= CORE_CALL;
        CORE_CALL: state_q <= pop ? CORE_RUN : CORE_ISR;
        CORE_ISR: if (pop) state_q <= CORE_RUN;
        default: state_q <= CORE_RUN;
      endcase
    end
  end

  // service flag, registered copy of state not equal to run
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      isr_q <= 1'b0;
    end else if (take) begin
      isr_q <= 1'b1;
    end else if (pop && (state_q != CORE_RUN)) begin
      isr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_q <= `PC_RESET;
      load_q <= 1'b0;
    end else if (take) begin
      pc_q <= `PC_W'(ctrl.vec_id);
      load_q <= 1'b1;
    end else if (pop) begin
      pc_q <= stack_q[3'(sp_q - 1'b1)];
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end

  assign ctrl.vec_take = take;
  assign ctrl.stack_full = stack_full;
  assign ctrl.return_from_interrupt = return_from_interrupt_i & (sp_q != '0);
  assign ctrl.ret = ret_i & (sp_q != '0);
  assign pc_o = pc_q;
  assign pc_load_o = load_q;
  assign in_isr_o = isr_q;
endmodule

// *** tb/int_wake_assertions.sv ***
// checker: timing relations on the controller-to-core interface
// assumes: instantiated in tb beside the interface, one clock domain
`timescale 1ns/1ps

module int_wake_assertions (
  input wire logic clk_sys_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic vec_req, // vector request
  input wire logic vec_take, // call taken
  input wire logic stack_full, // no stack room
  input wire logic return_from_interrupt, // return_from_interrupt
  input wire logic ret, // plain return
  input wire logic gie // global enable
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // service in progress, between a take and its return
  logic in_svc_q;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_svc_q <= 1'b0;
    end else if (vec_take) begin
      in_svc_q <= 1'b1;
    end else if (return_from_interrupt || ret) begin
      in_svc_q <= 1'b0;
    end
  end

  sequence s_take;
    vec_take;
  endsequence
  sequence s_gie_low2;
    !gie ##1 !gie;
  endsequence

  a_take_clears_gie: assert property (s_take |=> !gie)
    else $error("global enable still set after a call");
  a_take_needs_gie: assert property (s_take |-> gie)
    else $error("call taken with global enable clear");
  a_take_needs_room: assert property (s_take |-> vec_req && !stack_full)
    else $error("call taken without request or stack room");
  a_req_after_gie: assert property ($rose(vec_req) |-> $past(gie))
    else $error("request raised while global enable was clear");
  a_take_drops_req: assert property (s_take |=> !vec_req [*2])
    else $error("request still up after the call");
  a_one_take: assert property (s_take |-> !in_svc_q)
    else $error("second call inside a service");
  a_return_from_interrupt_sets_gie: assert property (return_from_interrupt |-> ##[1:2] gie)
    else $error("global enable not restored by return");
  a_ret_keeps_gie: assert property (ret |=> s_gie_low2)
    else $error("plain return set the global enable");
endmodule

// *** tb/tb.sv ***
// testbench: controller and core joined by the interface
// assumes: one 250 MHz clock, async active-low reset
`timescale 1ns/1ps

module tb;
  import int_wake_pkg::*;
  logic clk_sys_i, resetn_i, lp, gset, gclr, return_from_interrupt, ret, wake, pc_ld, in_isr;
  logic [6:0] ev;
  logic [2:0] ub;
  logic [5:0] uart;
  logic [3:0] en, fset, fclr, flags;
  logic [11:0] pc, pc_o;
  int seed = 32'h27b8;
  int err_total, checks, n;

  assign uart = ev[3] ? 6'(6'h01 << ub) : 6'h00;

  int_wake_if i_int_wake_if();
  int_wake_ctrl i_int_wake_ctrl(.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .core(i_int_wake_if.ctrl), .ser_byte_done_i(ev[0]), .ser_addr_match_i(ev[1]),
    .ser_timeout_i(ev[2]), .uart_status_flags_i(uart), .ee_erase_done_i(ev[4]),
    .ee_write_done_i(ev[5]), .filter_ready_status_i(ev[6]), .low_power_i(lp),
    .int_en_i(en), .gie_set_i(gset), .gie_clr_i(gclr), .flag_set_i(fset),
    .flag_clr_i(fclr), .req_flags_o(flags), .wake_o(wake));
  int_wake_core i_int_wake_core(.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .ctrl(i_int_wake_if.core), .pc_i(pc), .return_from_interrupt_i(return_from_interrupt), .ret_i(ret),
    .pc_o(pc_o), .pc_load_o(pc_ld), .in_isr_o(in_isr));
  int_wake_assertions i_int_wake_assertions(.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .vec_req(i_int_wake_if.vec_req),
    .vec_take(i_int_wake_if.vec_take), .stack_full(i_int_wake_if.stack_full),
    .return_from_interrupt(i_int_wake_if.return_from_interrupt), .ret(i_int_wake_if.ret), .gie(i_int_wake_if.gie));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task tick(int k = 1);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task chk(string name, logic [11:0] exp, logic [11:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic int src_of(int k);
    return k < 3 ? 0 : k == 3 ? 1 : k < 6 ? 2 : 3;
  endfunction
  // pulse events for one cycle, levels stay up until cleared
  task fire(logic [6:0] m);
    ub = 3'($unsigned($random(seed)) % 6);
    ev = m;
    tick();
    ev = m & 7'h48;
  endtask
  task wait_load(string name, logic [11:0] exp);
    n = 0;
    while (pc_ld !== 1'b1 && n < 30) begin
      tick();
      n++;
    end
    chk("pc load strobe", 12'h001, 12'(pc_ld));
    chk(name, exp, pc_o);
  endtask
  task gie_on();
    gset = 1'b1;
    tick();
    gset = 1'b0;
  endtask
  task ret_do(bit use_return_from_interrupt);
    return_from_interrupt = use_return_from_interrupt;
    ret = !use_return_from_interrupt;
    tick();
    return_from_interrupt = 1'b0;
    ret = 1'b0;
    wait_load("return pc", pc);
    tick(2);
  endtask
  task serve(int k, bit use_return_from_interrupt);
    int s;
    s = src_of(k);
    en = 4'(4'h1 << s);
    fire(7'(7'h01 << k));
    wait_load("vector pc", 12'(s));
    chk("gie after call", 12'h000, 12'(i_int_wake_if.gie));
    chk("in service", 12'h001, 12'(in_isr));
    tick(2);
    chk("flag after call", 12'h000, 12'(flags[s]));
    ev = 7'h00; // software clears source levels
    ret_do(use_return_from_interrupt); // no call inside service
    chk("gie after return", 12'(use_return_from_interrupt), 12'(i_int_wake_if.gie));
    chk("service ended", 12'h000, 12'(in_isr));
    if (!use_return_from_interrupt) begin
      gie_on();
    end
  endtask
  task count_wake();
    n = 0;
    repeat (8) begin
      n += int'(wake === 1'b1);
      tick();
    end
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #80000;
    err_total++;
    wrap_up();
  end
  initial begin
    {ev, ub, lp, en, gset, gclr, fset, fclr, return_from_interrupt, ret, pc} = '0;
    resetn_i = 1'b0;
    tick(6);
    resetn_i = 1'b1;
    gie_on();
    for (int k = 0; k < 7; k++) begin
      pc = 12'($random(seed));
      serve(k, k != 2);
    end
    $display("single source test done");
    en = 4'h0;
    fire(7'h59);
    tick(8);
    chk("flags held while disabled", 12'h00F, 12'(flags));
    en = 4'hF;
    ev = 7'h00;
    for (int i = 0; i < 4; i++) begin
      wait_load("priority pc", 12'(i));
      ret_do(1'b1);
    end
    $display("priority test done");
    en = 4'h0;
    lp = 1'b1;
    fire(7'h10);
    count_wake();
    chk("wake on flag rise", 12'h001, 12'(n));
    lp = 1'b0;
    fclr = 4'hF;
    tick();
    fclr = 4'h0;
    fset = 4'h8;
    tick();
    fset = 4'h0;
    lp = 1'b1;
    fire(7'h40);
    count_wake();
    chk("no wake with preset flag", 12'h000, 12'(n));
    $display("wake test done");
    lp = 1'b0;
    en = 4'h0;
    fclr = 4'hF;
    tick();
    fclr = 4'h0;
    gclr = 1'b1;
    tick();
    gclr = 1'b0;
    en = 4'h1;
    pc = 12'($random(seed));
    fire(7'h01);
    tick(4);
    chk("no call while gie clear", 12'h000, 12'(pc_ld));
    chk("flag held while gie clear", 12'h001, 12'(flags[0]));
    gie_on();
    wait_load("call after gie set", 12'h000);
    ret_do(1'b1);
    $display("gie gating test done");
    wrap_up();
  end
endmodule
